// *** qpt_pkg.sv ***
// Purpose : Shared constants for the quad PWM timer group
// Assumes : Byte addresses on a 12-bit register port, 32-bit data
// Notes   : One aligned word per register
package qpt_pkg;
    // ----------------------------------------
    // Sizes
    // ----------------------------------------
    localparam int NUM_TMR      = 4;
    localparam int NUM_UNIT     = 16;
    localparam int NUM_PWM_UNIT = 14;
    localparam int NUM_DT       = 7;
    localparam int CNT_W        = 16;
    localparam int DIV_W        = 3;
    localparam int DT_W         = 8;
    localparam int ADDR_W       = 12;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [11:0] GLOB_OFS    = 12'h000;
    localparam logic [11:0] TMR_BASE    = 12'h100;
    localparam logic [11:0] TMR_STRIDE  = 12'h010;
    localparam logic [11:0] TMR_CTL_OFS = 12'h000;
    localparam logic [11:0] TMR_PRD_OFS = 12'h004;
    localparam logic [11:0] TMR_CNT_OFS = 12'h008;
    localparam logic [11:0] UNIT_BASE   = 12'h200;
    localparam logic [11:0] UNIT_STRIDE = 12'h008;
    localparam logic [11:0] UNIT_CTL    = 12'h000;
    localparam logic [11:0] UNIT_VAL    = 12'h004;
    localparam logic [11:0] DT_BASE     = 12'h300;
    localparam logic [11:0] DT_STRIDE   = 12'h004;
    // ----------------------------------------
    // Field positions and reset values
    // ----------------------------------------
    localparam int GLOB_CONC_BIT = 0;
    localparam int CTL_RUN_BIT   = 0;
    localparam int CTL_SEL_BIT   = 1;
    localparam int CTL_DIV_LSB   = 2;
    localparam int UC_CAP_BIT    = 0;
    localparam int UC_CFLG_BIT   = 1;
    localparam int UC_MFLG_BIT   = 2;
    localparam int UC_PWM_BIT    = 3;
    localparam logic [15:0] PRD_RST = 16'hffff;
    localparam logic [15:0] VAL_RST = 16'h0000;
    localparam logic [7:0]  DT_RST  = 8'h00;

    // Owning timer of each unit: A 0-7, B 8-9, C 10-11, D 12-13, B time bases 14-15
    function automatic int unit_tmr(int u);
        if (u < 8) return 0;
        if (u < 10) return 1;
        if (u < 12) return 2;
        if (u < 14) return 3;
        return 1;
    endfunction

    function automatic logic [11:0] reg_at(logic [11:0] base, logic [11:0] step,
                                           int i, logic [11:0] ofs);
        return 12'(int'(base) + i * int'(step)) + ofs;
    endfunction
endpackage

// *** qpt_timer.sv ***
// Purpose : Prescaler and 16-bit up counter of one timer
// Assumes : tick_src is a one-cycle enable of the selected clock source
// Notes   : step is the combinational advance, adv its registered copy
`timescale 1ns/1ps
module qpt_timer
    import qpt_pkg::*;
#(
    parameter int W = CNT_W
)(
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         reset,
    // Control
    input  wire logic         tick_src,
    input  wire logic         run,
    input  wire logic [2:0]   div,
    input  wire logic [W-1:0] period,
    // Status
    output logic              step,
    output logic              adv,
    output logic [W-1:0]      count
);
    if (W < 2 || W > 32) begin : g_chk
        $error("qpt_timer: counter width out of range");
    end

    typedef struct packed {
        logic [6:0]   pre;
        logic [W-1:0] cnt;
        logic         adv;
    } qpt_tmr_state_t;

    qpt_tmr_state_t s_reg;
    qpt_tmr_state_t s_next;
    logic [6:0]     lim;

    // Divide ratio 1..128 as a power of two
    assign lim   = 7'((8'h01 << div) - 8'h01);
    assign step  = run && tick_src && (s_reg.pre >= lim);
    assign adv   = s_reg.adv;
    assign count = s_reg.cnt;

    // Prescale the selected tick, then count up and wrap at period
    always_comb begin
        s_next     = s_reg;
        s_next.adv = 1'b0;
        if (!run) begin
            s_next.pre = 7'h00;
        end else if (tick_src) begin
            if (step) begin
                s_next.pre = 7'h00;
                s_next.adv = 1'b1;
                s_next.cnt = (s_reg.cnt >= period) ? '0 : W'(s_reg.cnt + 1'b1);
            end else begin
                s_next.pre = 7'(s_reg.pre + 7'h01);
            end
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    src_gate_a: assert property (@(posedge sys_clk) disable iff (reset)
        s_reg.adv |-> $past(tick_src && run))
        else $error("counter advanced without a source tick");
    div_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
        (run && $stable(div) && s_reg.pre < lim) |=> !s_reg.adv)
        else $error("counter advanced before prescaler expired");
    cnt_step_a: assert property (@(posedge sys_clk) disable iff (reset)
        s_reg.adv |-> (s_reg.cnt == '0 || s_reg.cnt == W'($past(s_reg.cnt) + 1'b1)))
        else $error("counter step is not plus one or wrap");
endmodule

// *** qpt_deadtime.sv ***
// Purpose : Dead-time controller turning one drive level into a gate pair
// Assumes : dead is held stable while a transition is in progress
// Notes   : Both outputs are off during reset and for dead+1 cycles per edge
`timescale 1ns/1ps
module qpt_deadtime
    import qpt_pkg::*;
#(
    parameter int W = DT_W
)(
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         reset,
    // Drive and setting
    input  wire logic         src,
    input  wire logic [W-1:0] dead,
    // Gate pair
    output logic              hi,
    output logic              lo
);
    if (W < 1 || W > 16) begin : g_chk
        $error("qpt_deadtime: dead-time width out of range");
    end

    typedef struct packed {
        logic         cur;
        logic         settled;
        logic [W-1:0] cnt;
        logic [W:0]   off_len;
        logic         hi;
        logic         lo;
    } qpt_dt_state_t;

    qpt_dt_state_t s_reg;
    qpt_dt_state_t s_next;

    assign hi = s_reg.hi;
    assign lo = s_reg.lo;

    // Drop both sides on a change, wait dead cycles, then turn on the new side
    always_comb begin
        s_next = s_reg;
        if (s_reg.settled) begin
            if (src != s_reg.cur) begin
                s_next.settled = 1'b0;
                s_next.cnt     = dead;
            end
        end else if (s_reg.cnt == '0) begin
            s_next.cur     = src;
            s_next.settled = 1'b1;
        end else begin
            s_next.cnt = W'(s_reg.cnt - 1'b1);
        end
        s_next.hi = s_next.cur && s_next.settled;
        s_next.lo = !s_next.cur && s_next.settled;
        if (s_reg.hi || s_reg.lo) begin
            s_next.off_len = '0;
        end else if (!(&s_reg.off_len)) begin
            s_next.off_len = (W+1)'(s_reg.off_len + 1'b1);
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    never_both_a: assert property (@(posedge sys_clk) disable iff (reset)
        !(s_reg.hi && s_reg.lo))
        else $error("both gate outputs active");
    dead_gap_a: assert property (@(posedge sys_clk) disable iff (reset)
        ($rose(s_reg.hi) || $rose(s_reg.lo)) |-> (s_reg.off_len > {1'b0, dead}))
        else $error("turn-on came before the dead time elapsed");
endmodule

// *** qpt_top.sv ***
// Purpose : Quad 16-bit timer group with PWM, capture/compare and dead time
// Assumes : Register port strobes are one cycle; inputs synchronous to sys_clk
// Notes   : Bus clock source ticks every sys_clk cycle; aux source on aux_clk_tick
//
// Behaviour
// - The group drives 14 PWM outputs through 7 dead-time controllers.
// - Timer A is a 16-bit counter owning eight PWM or capture/compare units.
// - Timer A units form four pairs, each pair driving its own dead-time controller.
// - Timer B has two PWM or capture/compare units feeding one dead-time controller.
// - Timer B has two more compare-only units that serve as time-base events.
// - Timer C has two PWM or capture/compare units feeding one dead-time controller.
// - Timer D has two PWM or capture/compare units feeding one dead-time controller.
// - Each timer counts from the auxiliary source or the bus clock, chosen by software.
// - Each timer divides its chosen source by 1 to 128 before the counter.
// - Concatenated timers share timer A's clock and start/stop so they stay in step.
`timescale 1ns/1ps
module qpt_top
    import qpt_pkg::*;
(
    // Clock and reset
    input  wire logic                    sys_clk,
    input  wire logic                    reset,
    // Register port
    input  wire logic [ADDR_W-1:0]       reg_addr,
    input  wire logic [31:0]             reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic      [31:0]             reg_rdata,
    // Clock source and capture inputs
    input  wire logic                    aux_clk_tick,
    input  wire logic [NUM_PWM_UNIT-1:0] cap_in,
    // Gate pairs and time-base events
    output logic      [NUM_DT-1:0]       pwm_hi,
    output logic      [NUM_DT-1:0]       pwm_lo,
    output logic      [1:0]              tbase_evt
);
    // ----------------------------------------
    // Elaboration checks
    // ----------------------------------------
    if (NUM_PWM_UNIT != 2 * NUM_DT || NUM_UNIT != NUM_PWM_UNIT + 2) begin : g_chk
        $error("qpt_top: unit and pair counts disagree");
    end

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic                                conc;
        logic [NUM_TMR-1:0]                  run;
        logic [NUM_TMR-1:0]                  sel;
        logic [NUM_TMR-1:0][DIV_W-1:0]       div;
        logic [NUM_TMR-1:0][CNT_W-1:0]       prd;
        logic [NUM_UNIT-1:0]                 cap_mode;
        logic [NUM_UNIT-1:0]                 cap_flag;
        logic [NUM_UNIT-1:0]                 match_flag;
        logic [NUM_UNIT-1:0][CNT_W-1:0]      val;
        logic [NUM_PWM_UNIT-1:0]             cap_prev;
        logic [NUM_PWM_UNIT-1:0]             pwm;
        logic [NUM_DT-1:0][DT_W-1:0]         dt;
        logic [1:0]                          tbase;
        logic [31:0]                         rdata;
    } qpt_top_state_t;

    qpt_top_state_t                s_reg;
    qpt_top_state_t                s_next;
    logic [NUM_TMR-1:0]            run_eff;
    logic [NUM_TMR-1:0]            step_w;
    logic [NUM_TMR-1:0]            adv_w;
    logic [NUM_TMR-1:0][CNT_W-1:0] cnt_w;
    logic [NUM_UNIT-1:0]           hit;
    logic [NUM_UNIT-1:0]           cap_ev;
    logic [NUM_PWM_UNIT-1:0]       cmp_lvl;
    logic [NUM_DT-1:0]             drv;

    assign reg_rdata = s_reg.rdata;
    assign tbase_evt = s_reg.tbase;

    // ----------------------------------------
    // Timers
    // ----------------------------------------
    for (genvar t = 0; t < NUM_TMR; t++) begin : g_tmr
        logic       src;
        logic [2:0] div_eff;

        // Concatenated timers follow timer A's start/stop
        assign run_eff[t] = s_reg.conc ? s_reg.run[0] : s_reg.run[t];

        if (t == 0) begin : g_lead
            // Bus clock ticks every cycle, aux source on its enable
            assign src     = s_reg.sel[0] ? aux_clk_tick : 1'b1;
            assign div_eff = s_reg.div[0];
        end else begin : g_follow
            // Followers take timer A's divided tick undivided when concatenated
            assign src     = s_reg.conc ? step_w[0]
                           : (s_reg.sel[t] ? aux_clk_tick : 1'b1);
            assign div_eff = s_reg.conc ? 3'h0 : s_reg.div[t];
        end

        qpt_timer #(
            .W (CNT_W)
        ) u_tmr (
            .sys_clk  (sys_clk),
            .reset    (reset),
            .tick_src (src),
            .run      (run_eff[t]),
            .div      (div_eff),
            .period   (s_reg.prd[t]),
            .step     (step_w[t]),
            .adv      (adv_w[t]),
            .count    (cnt_w[t])
        );
    end

    // ----------------------------------------
    // Capture/compare units
    // ----------------------------------------
    for (genvar u = 0; u < NUM_UNIT; u++) begin : g_unit
        localparam int T = unit_tmr(u);

        // Compare match on the cycle the counter reaches the value
        assign hit[u] = adv_w[T] && !s_reg.cap_mode[u] && (cnt_w[T] == s_reg.val[u]);

        if (u < NUM_PWM_UNIT) begin : g_pwm
            // PWM level high while the count is below the compare value
            assign cmp_lvl[u] = run_eff[T] && !s_reg.cap_mode[u]
                              && (cnt_w[T] < s_reg.val[u]);
            // Capture on a rising capture input
            assign cap_ev[u]  = s_reg.cap_mode[u] && cap_in[u] && !s_reg.cap_prev[u];

            cap_load_a: assert property (@(posedge sys_clk) disable iff (reset)
                cap_ev[u] |=> (s_reg.cap_flag[u] && s_reg.val[u] == $past(cnt_w[T])))
                else $error("capture did not load the count and flag");
        end else begin : g_tbase
            // Time-base units have no PWM output and no capture
            assign cap_ev[u] = 1'b0;

            tbase_hit_a: assert property (@(posedge sys_clk) disable iff (reset)
                hit[u] |=> (s_reg.tbase[u-NUM_PWM_UNIT] && s_reg.match_flag[u]))
                else $error("time-base match lost");
        end
    end

    // ----------------------------------------
    // Dead-time pairs
    // ----------------------------------------
    // Even unit sets the trailing edge, odd unit the leading edge
    for (genvar d = 0; d < NUM_DT; d++) begin : g_dt
        assign drv[d] = s_reg.pwm[2*d] && !s_reg.pwm[2*d+1];

        qpt_deadtime #(
            .W (DT_W)
        ) u_dt (
            .sys_clk (sys_clk),
            .reset   (reset),
            .src     (drv[d]),
            .dead    (s_reg.dt[d]),
            .hi      (pwm_hi[d]),
            .lo      (pwm_lo[d])
        );
    end

    // ----------------------------------------
    // Register writes, reads and unit state
    // ----------------------------------------
    always_comb begin
        logic wr_c;
        logic wr_v;
        logic rd_c;
        wr_c         = 1'b0;
        wr_v         = 1'b0;
        rd_c         = 1'b0;
        s_next       = s_reg;
        s_next.pwm   = cmp_lvl;
        s_next.cap_prev = cap_in;
        s_next.tbase = hit[NUM_UNIT-1:NUM_PWM_UNIT];
        // Global control
        if (reg_wr && reg_addr == GLOB_OFS) begin
            s_next.conc = reg_wdata[GLOB_CONC_BIT];
        end
        // Timer control and period
        for (int t = 0; t < NUM_TMR; t++) begin
            if (reg_wr && reg_addr == reg_at(TMR_BASE, TMR_STRIDE, t, TMR_CTL_OFS)) begin
                s_next.run[t] = reg_wdata[CTL_RUN_BIT];
                s_next.sel[t] = reg_wdata[CTL_SEL_BIT];
                s_next.div[t] = reg_wdata[CTL_DIV_LSB +: DIV_W];
            end
            if (reg_wr && reg_addr == reg_at(TMR_BASE, TMR_STRIDE, t, TMR_PRD_OFS)) begin
                s_next.prd[t] = reg_wdata[CNT_W-1:0];
            end
        end
        // Units: flags clear by writing one, an event in that cycle wins
        for (int u = 0; u < NUM_UNIT; u++) begin
            wr_c = reg_wr && reg_addr == reg_at(UNIT_BASE, UNIT_STRIDE, u, UNIT_CTL);
            wr_v = reg_wr && reg_addr == reg_at(UNIT_BASE, UNIT_STRIDE, u, UNIT_VAL);
            if (wr_c) begin
                s_next.cap_mode[u] = reg_wdata[UC_CAP_BIT] && (u < NUM_PWM_UNIT);
            end
            if (wr_v) begin
                s_next.val[u] = reg_wdata[CNT_W-1:0];
            end
            if (cap_ev[u]) begin
                s_next.val[u] = cnt_w[unit_tmr(u)];
            end
            s_next.cap_flag[u] = (s_reg.cap_flag[u] && !(wr_c && reg_wdata[UC_CFLG_BIT]))
                               || cap_ev[u];
            s_next.match_flag[u] = (s_reg.match_flag[u]
                                 && !(wr_c && reg_wdata[UC_MFLG_BIT])) || hit[u];
        end
        // Dead-time settings
        for (int d = 0; d < NUM_DT; d++) begin
            if (reg_wr && reg_addr == reg_at(DT_BASE, DT_STRIDE, d, 12'h000)) begin
                s_next.dt[d] = reg_wdata[DT_W-1:0];
            end
        end
        // Read data stands only in the cycle after the read strobe
        s_next.rdata = 32'h0000_0000;
        if (reg_rd) begin
            if (reg_addr == GLOB_OFS) begin
                s_next.rdata[GLOB_CONC_BIT] = s_reg.conc;
            end
            for (int t = 0; t < NUM_TMR; t++) begin
                rd_c = reg_addr == reg_at(TMR_BASE, TMR_STRIDE, t, TMR_CTL_OFS);
                if (rd_c) begin
                    s_next.rdata[CTL_RUN_BIT]            = s_reg.run[t];
                    s_next.rdata[CTL_SEL_BIT]            = s_reg.sel[t];
                    s_next.rdata[CTL_DIV_LSB +: DIV_W]   = s_reg.div[t];
                end
                if (reg_addr == reg_at(TMR_BASE, TMR_STRIDE, t, TMR_PRD_OFS)) begin
                    s_next.rdata[CNT_W-1:0] = s_reg.prd[t];
                end
                if (reg_addr == reg_at(TMR_BASE, TMR_STRIDE, t, TMR_CNT_OFS)) begin
                    s_next.rdata[CNT_W-1:0] = cnt_w[t];
                end
            end
            for (int u = 0; u < NUM_UNIT; u++) begin
                if (reg_addr == reg_at(UNIT_BASE, UNIT_STRIDE, u, UNIT_CTL)) begin
                    s_next.rdata[UC_CAP_BIT]  = s_reg.cap_mode[u];
                    s_next.rdata[UC_CFLG_BIT] = s_reg.cap_flag[u];
                    s_next.rdata[UC_MFLG_BIT] = s_reg.match_flag[u];
                    if (u < NUM_PWM_UNIT) begin
                        s_next.rdata[UC_PWM_BIT] = s_reg.pwm[u];
                    end
                end
                if (reg_addr == reg_at(UNIT_BASE, UNIT_STRIDE, u, UNIT_VAL)) begin
                    s_next.rdata[CNT_W-1:0] = s_reg.val[u];
                end
            end
            for (int d = 0; d < NUM_DT; d++) begin
                if (reg_addr == reg_at(DT_BASE, DT_STRIDE, d, 12'h000)) begin
                    s_next.rdata[DT_W-1:0] = s_reg.dt[d];
                end
            end
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            s_reg <= '0;
            for (int t = 0; t < NUM_TMR; t++) begin
                s_reg.prd[t] <= PRD_RST;
            end
            for (int u = 0; u < NUM_UNIT; u++) begin
                s_reg.val[u] <= VAL_RST;
            end
            for (int d = 0; d < NUM_DT; d++) begin
                s_reg.dt[d] <= DT_RST;
            end
        end else begin
            s_reg <= s_next;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence bus_src_s;
        s_reg.run[0] && !s_reg.sel[0] && s_reg.div[0] == 3'h0;
    endsequence

    sequence conc_held_s;
        s_reg.conc ##1 s_reg.conc;
    endsequence

    conc_sync_a: assert property (@(posedge sys_clk) disable iff (reset)
        conc_held_s |-> (adv_w == {NUM_TMR{adv_w[0]}}))
        else $error("concatenated timers advanced apart");

    bus_tick_a: assert property (@(posedge sys_clk) disable iff (reset)
        bus_src_s ##1 bus_src_s |-> adv_w[0])
        else $error("bus clock source with ratio one missed a count");

    pair_src_a: assert property (@(posedge sys_clk) disable iff (reset)
        (drv[0] && s_reg.dt[0] == 8'h00)[*3] |-> (pwm_hi[0] && !pwm_lo[0]))
        else $error("pair 0 did not follow its drive level");

    flag_keep_a: assert property (@(posedge sys_clk) disable iff (reset)
        (s_reg.match_flag[0] && !reg_wr) |=> s_reg.match_flag[0])
        else $error("match flag dropped without a clear");

    rd_once_a: assert property (@(posedge sys_clk) disable iff (reset)
        (reg_rd && reg_addr == reg_at(TMR_BASE, TMR_STRIDE, 0, TMR_CTL_OFS))
        |=> (reg_rdata[CTL_SEL_BIT] == $past(s_reg.sel[0])) ##1 (reg_rdata == 32'h0
        || $past(reg_rd)))
        else $error("timer control read back wrong");
endmodule

// *** qpt_gate_model.sv ***
// Purpose : Gate-driver model standing on the seven output pairs
// Assumes : Both gate inputs of a pair are active high
// Notes   : Counts high-side turn-ons and flags both gates on at once
`timescale 1ns/1ps
module qpt_gate_model (
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       reset,
    // Gate pairs
    input wire logic [6:0] hi,
    input wire logic [6:0] lo
);
    int         ons [7];
    int         shoot;
    logic [6:0] hi_q;
    // Count turn-ons and catch shoot-through
    always @(posedge sys_clk) begin
        for (int d = 0; d < 7; d++) begin
            if (!reset && hi[d] === 1'b1 && hi_q[d] !== 1'b1) ons[d]++;
            if (hi[d] === 1'b1 && lo[d] === 1'b1) shoot++;
        end
        hi_q <= hi;
    end
endmodule

// *** qpt_top_tb.sv ***
// Purpose : Self-checking bench for the quad PWM timer group
// Assumes : Register reads return data one cycle after the strobe
// Notes   : Counts are judged inside a small window around the ideal
`timescale 1ns/1ps
module qpt_top_tb;
    import qpt_pkg::*;
    logic sys_clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, aux_clk_tick = 0;
    logic [11:0] reg_addr = 0;
    logic [31:0] reg_wdata = 0, reg_rdata, d0, d1, e0, e1;
    logic [13:0] cap_in = 0;
    logic [6:0]  pwm_hi, pwm_lo;
    logic [1:0]  tbase_evt;
    int          num_errors = 0, checked = 0, tb0 = 0, tb1 = 0;
    qpt_top qpt_top_inst (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .aux_clk_tick(aux_clk_tick), .cap_in(cap_in), .pwm_hi(pwm_hi), .pwm_lo(pwm_lo),
        .tbase_evt(tbase_evt));
    qpt_gate_model qpt_gate_model_inst (.sys_clk(sys_clk), .reset(reset), .hi(pwm_hi),
        .lo(pwm_lo));
    // ----------------------------------------
    // Clock, aux ticks every 4th cycle, time-base event counts
    // ----------------------------------------
    initial forever #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        aux_clk_tick <= ($time % 16 == 2);
        if (tbase_evt[0] === 1'b1) tb0++;
        if (tbase_evt[1] === 1'b1) tb1++;
    end
    // ----------------------------------------
    // Register port and compares
    // ----------------------------------------
    task wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a; reg_wdata <= d; reg_wr <= 1;
        @(posedge sys_clk);
        reg_wr <= 0;
    endtask
    task rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a; reg_rd <= 1;
        @(posedge sys_clk);
        reg_rd <= 0;
        #1 d = reg_rdata;
    endtask
    task chk_word(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task chk_range(input logic [31:0] got, input int lo, input int hi);
        chk_word(32'(got >= lo && got <= hi), 32'h1);
    endtask
    function automatic logic [11:0] ta(int t, logic [11:0] o);
        return TMR_BASE + 12'(16 * t) + o;
    endfunction
    function automatic logic [11:0] ua(int u, logic [11:0] o);
        return UNIT_BASE + 12'(8 * u) + o;
    endfunction
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task reset_values;
        for (int t = 0; t < 4; t++) begin
            rd(ta(t, TMR_PRD_OFS), d0); chk_word(d0, 32'h0000ffff);
            rd(ta(t, TMR_CTL_OFS), d0); chk_word(d0, 32'h0);
        end
        rd(12'h0f0, d0); chk_word(d0, 32'h0);
        rd(DT_BASE + 12'h018, d0); chk_word(d0, 32'h0);
        chk_word(32'({pwm_hi, pwm_lo}), 32'h0000007f);
    endtask
    task divider_and_source;
        for (int t = 0; t < 3; t++) begin
            wr(ta(t, TMR_CTL_OFS), 32'(((t * 3 + t / 2) << 2) | 1));
            repeat (10 << (t * 3 + t / 2)) @(posedge sys_clk);
            wr(ta(t, TMR_CTL_OFS), 32'h0);
            rd(ta(t, TMR_CNT_OFS), d0); chk_range(d0, 9, 12);
        end
        wr(ta(3, TMR_CTL_OFS), 32'h3);
        repeat (40) @(posedge sys_clk);
        wr(ta(3, TMR_CTL_OFS), 32'h0);
        rd(ta(3, TMR_CNT_OFS), d0); chk_range(d0, 9, 12);
    endtask
    task concatenate;
        rd(ta(0, TMR_CNT_OFS), d0); rd(ta(3, TMR_CNT_OFS), e0);
        wr(GLOB_OFS, 32'h1);
        wr(ta(0, TMR_CTL_OFS), 32'h5);
        repeat (40) @(posedge sys_clk);
        wr(ta(0, TMR_CTL_OFS), 32'h0);
        rd(ta(0, TMR_CNT_OFS), d1); rd(ta(3, TMR_CNT_OFS), e1);
        chk_range(d1 - d0, 19, 23);
        chk_word(e1 - e0, d1 - d0);
    endtask
    task pwm_pairs;
        for (int t = 0; t < 4; t++) wr(ta(t, TMR_PRD_OFS), 32'h9);
        for (int d = 0; d < 7; d++) wr(DT_BASE + 12'(4 * d), 32'(d == 0 ? 0 : 2));
        for (int d = 0; d < 7; d++) wr(ua(2 * d, UNIT_VAL), 32'h5);
        wr(ua(14, UNIT_VAL), 32'h3); wr(ua(15, UNIT_VAL), 32'h7);
        tb0 = 0; tb1 = 0;
        wr(ta(0, TMR_CTL_OFS), 32'h1);
        repeat (200) @(posedge sys_clk);
        for (int d = 0; d < 7; d++) chk_range(qpt_gate_model_inst.ons[d], 19, 21);
        chk_range(tb0, 19, 21); chk_range(tb1, 19, 21);
        chk_word(qpt_gate_model_inst.shoot, 32'h0);
    endtask
    task capture;
        wr(ua(10, UNIT_CTL), 32'h1);
        @(posedge sys_clk) cap_in <= 14'h0400;
        @(posedge sys_clk) cap_in <= 14'h0000;
        repeat (3) @(posedge sys_clk);
        rd(ua(10, UNIT_CTL), d0); chk_word(d0 & 32'h7, 32'h7);
        wr(ua(10, UNIT_CTL), 32'h3);
        rd(ua(10, UNIT_CTL), d0); chk_word(d0 & 32'h7, 32'h5);
        wr(ua(10, UNIT_CTL), 32'h5);
        rd(ua(10, UNIT_CTL), d0); chk_word(d0 & 32'h7, 32'h1);
        rd(ua(10, UNIT_VAL), d0); chk_range(d0, 0, 9);
    endtask
    task results;
        $display("compares=%0d mismatches=%0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge sys_clk);
        reset <= 0;
        reset_values(); divider_and_source(); concatenate(); pwm_pairs(); capture();
        results();
    end
    initial begin
        #100000;
        num_errors++;
        results();
    end
endmodule
